// ==== design/instruction_cycle_timing.sv ====
// Summary of operation
// - A quoted time is the whole clock count and its read, prefetch and write cycles lie inside it.
// - A memory bit field over five bytes takes two operand cycles, within four bytes only one.
// - Memory bit field forms add the immediate address calculation time to their count.
// - Branch and loop-decrement counts are complete, a taken branch costing 3, 6 or 9 clocks.
// - A loop decrement with false condition and live counter costs as a taken branch.
// - A loop decrement with false condition and expired counter costs 7, 10 or 10 clocks.
// - A stack-copy type-1 module call adds six clocks, one read and one write per transfer.
// - Jump and jump-to-subroutine add jump address time, a jump costing 1 up to 7 clocks.
// - The register bounds check costs 8 clocks plus the operand fetch time.
// - Load and push effective address add calculation time, the load costing 2 at best.
// - Module calls and the range check add immediate fetch time, type 0 doing 2 reads, 6 writes.
`timescale 1ns/1ns
`default_nettype none

module instruction_cycle_timing (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Request
  input wire logic start,
  input wire instruction_cycle_timing_pkg::request_s req,
  output logic ready,
  // Answer
  output instruction_cycle_timing_pkg::result_s result,
  output logic busy,
  output logic done
);

  typedef enum {ST_IDLE, ST_RUN} state_e;

  // Builds one timing record
  function automatic instruction_cycle_timing_pkg::timing_s ts(input int t, input int r,
                                                              input int p, input int w);
    instruction_cycle_timing_pkg::timing_s x;
    x.total = 16'(t);
    x.reads = 8'(r);
    x.prefetches = 8'(p);
    x.writes = 8'(w);
    return x;
  endfunction

  // Bit field row by operand form
  function automatic instruction_cycle_timing_pkg::row_t bf_row(
      input instruction_cycle_timing_pkg::op_e op, input instruction_cycle_timing_pkg::form_e f);
    instruction_cycle_timing_pkg::row_t r;
    r = {ts(0, 0, 0, 0), ts(0, 0, 0, 0), ts(0, 0, 0, 0)};
    unique case (op)
      instruction_cycle_timing_pkg::OP_BF_TEST: begin
        unique case (f)
          instruction_cycle_timing_pkg::FORM_REG: r = {ts(7, 0, 1, 0), ts(6, 0, 0, 0), ts(3, 0, 0, 0)};
          instruction_cycle_timing_pkg::FORM_MEM_FOUR: r = {ts(12, 1, 1, 0), ts(11, 1, 0, 0), ts(11, 1, 0, 0)};
          default: r = {ts(16, 2, 1, 0), ts(15, 2, 0, 0), ts(15, 2, 0, 0)};
        endcase
      end
      instruction_cycle_timing_pkg::OP_BF_CHANGE, instruction_cycle_timing_pkg::OP_BF_CLEAR,
      instruction_cycle_timing_pkg::OP_BF_SET: begin
        unique case (f)
          instruction_cycle_timing_pkg::FORM_REG: r = {ts(12, 0, 1, 0), ts(12, 0, 0, 0), ts(9, 0, 0, 0)};
          instruction_cycle_timing_pkg::FORM_MEM_FOUR: r = {ts(16, 1, 1, 1), ts(16, 1, 0, 1), ts(16, 1, 0, 1)};
          default: r = {ts(24, 2, 1, 2), ts(24, 2, 0, 2), ts(24, 2, 0, 2)};
        endcase
      end
      instruction_cycle_timing_pkg::OP_BF_EXTRACT_SIGNED,
      instruction_cycle_timing_pkg::OP_BF_EXTRACT_UNSIGNED: begin
        unique case (f)
          instruction_cycle_timing_pkg::FORM_REG: r = {ts(8, 0, 1, 0), ts(8, 0, 0, 0), ts(5, 0, 0, 0)};
          instruction_cycle_timing_pkg::FORM_MEM_FOUR: r = {ts(13, 1, 1, 0), ts(13, 1, 0, 0), ts(13, 1, 0, 0)};
          default: r = {ts(18, 2, 1, 0), ts(18, 2, 0, 0), ts(18, 2, 0, 0)};
        endcase
      end
      instruction_cycle_timing_pkg::OP_BF_INSERT: begin
        unique case (f)
          instruction_cycle_timing_pkg::FORM_REG: r = {ts(10, 0, 1, 0), ts(10, 0, 0, 0), ts(7, 0, 0, 0)};
          instruction_cycle_timing_pkg::FORM_MEM_FOUR: r = {ts(15, 1, 1, 1), ts(14, 1, 0, 1), ts(14, 1, 0, 1)};
          default: r = {ts(21, 2, 1, 2), ts(20, 2, 0, 2), ts(20, 2, 0, 2)};
        endcase
      end
      default: begin
        unique case (f)
          instruction_cycle_timing_pkg::FORM_REG: r = {ts(18, 0, 1, 0), ts(18, 0, 0, 0), ts(15, 0, 0, 0)};
          instruction_cycle_timing_pkg::FORM_MEM_FOUR: r = {ts(24, 1, 1, 0), ts(24, 1, 0, 0), ts(24, 1, 0, 0)};
          default: r = {ts(32, 2, 1, 0), ts(32, 2, 0, 0), ts(32, 2, 0, 0)};
        endcase
      end
    endcase
    return r;
  endfunction

  // Branch and control rows
  function automatic instruction_cycle_timing_pkg::row_t ctl_row(
      input instruction_cycle_timing_pkg::op_e op);
    instruction_cycle_timing_pkg::row_t r;
    r = {ts(3, 0, 1, 0), ts(2, 0, 0, 0), ts(2, 0, 0, 0)};
    unique case (op)
      instruction_cycle_timing_pkg::OP_BRANCH_TAKEN,
      instruction_cycle_timing_pkg::OP_BRANCH_LONG_NOT_TAKEN,
      instruction_cycle_timing_pkg::OP_DECREMENT_AND_BRANCH_LOOP:
        r = {ts(9, 0, 2, 0), ts(6, 0, 0, 0), ts(3, 0, 0, 0)};
      instruction_cycle_timing_pkg::OP_BRANCH_BYTE_NOT_TAKEN:
        r = {ts(5, 0, 1, 0), ts(4, 0, 0, 0), ts(1, 0, 0, 0)};
      instruction_cycle_timing_pkg::OP_BRANCH_WORD_NOT_TAKEN,
      instruction_cycle_timing_pkg::OP_DECREMENT_AND_BRANCH_TRUE:
        r = {ts(7, 0, 1, 0), ts(6, 0, 0, 0), ts(3, 0, 0, 0)};
      instruction_cycle_timing_pkg::OP_DECREMENT_AND_BRANCH_EXPIRED:
        r = {ts(10, 0, 3, 0), ts(10, 0, 0, 0), ts(7, 0, 0, 0)};
      instruction_cycle_timing_pkg::OP_MODULE_CALL_TYPE0:
        r = {ts(36, 2, 2, 6), ts(30, 2, 0, 6), ts(28, 2, 0, 6)};
      instruction_cycle_timing_pkg::OP_MODULE_CALL_TYPE1_NO_COPY:
        r = {ts(56, 5, 2, 8), ts(50, 5, 0, 8), ts(48, 5, 0, 8)};
      instruction_cycle_timing_pkg::OP_MODULE_CALL_TYPE1_NO_COPY_ALT:
        r = {ts(64, 6, 2, 8), ts(57, 6, 0, 8), ts(55, 6, 0, 8)};
      instruction_cycle_timing_pkg::OP_MODULE_CALL_TYPE1_COPY:
        r = {ts(71, 7, 2, 8), ts(65, 7, 0, 8), ts(63, 7, 0, 8)};
      instruction_cycle_timing_pkg::OP_JUMP:
        r = {ts(7, 0, 2, 0), ts(4, 0, 0, 0), ts(1, 0, 0, 0)};
      instruction_cycle_timing_pkg::OP_JUMP_TO_SUBROUTINE:
        r = {ts(11, 0, 2, 1), ts(5, 0, 0, 1), ts(3, 0, 0, 1)};
      instruction_cycle_timing_pkg::OP_REGISTER_BOUNDS_CHECK:
        r = {ts(8, 0, 1, 0), ts(8, 0, 0, 0), ts(8, 0, 0, 0)};
      instruction_cycle_timing_pkg::OP_TWO_BOUND_RANGE_CHECK:
        r = {ts(18, 2, 1, 0), ts(18, 2, 0, 0), ts(16, 2, 0, 0)};
      instruction_cycle_timing_pkg::OP_LOAD_EFFECTIVE_ADDRESS:
        r = {ts(3, 0, 1, 0), ts(2, 0, 0, 0), ts(2, 0, 0, 0)};
      instruction_cycle_timing_pkg::OP_PUSH_EFFECTIVE_ADDRESS:
        r = {ts(6, 0, 1, 1), ts(5, 0, 0, 1), ts(3, 0, 0, 1)};
      default: r = {ts(3, 0, 1, 0), ts(2, 0, 0, 0), ts(2, 0, 0, 0)};
    endcase
    return r;
  endfunction

  // Which address time the instruction takes on top of its row
  function automatic instruction_cycle_timing_pkg::ea_e ea_of(
      input instruction_cycle_timing_pkg::op_e op, input logic on_memory);
    unique case (op)
      instruction_cycle_timing_pkg::OP_BF_TEST, instruction_cycle_timing_pkg::OP_BF_CHANGE,
      instruction_cycle_timing_pkg::OP_BF_CLEAR, instruction_cycle_timing_pkg::OP_BF_SET,
      instruction_cycle_timing_pkg::OP_BF_EXTRACT_SIGNED,
      instruction_cycle_timing_pkg::OP_BF_EXTRACT_UNSIGNED,
      instruction_cycle_timing_pkg::OP_BF_INSERT, instruction_cycle_timing_pkg::OP_BF_FIND_FIRST_ONE:
        return on_memory ? instruction_cycle_timing_pkg::EA_CALC_IMM
                         : instruction_cycle_timing_pkg::EA_NONE;
      instruction_cycle_timing_pkg::OP_MODULE_CALL_TYPE0,
      instruction_cycle_timing_pkg::OP_MODULE_CALL_TYPE1_NO_COPY,
      instruction_cycle_timing_pkg::OP_MODULE_CALL_TYPE1_NO_COPY_ALT,
      instruction_cycle_timing_pkg::OP_MODULE_CALL_TYPE1_COPY,
      instruction_cycle_timing_pkg::OP_TWO_BOUND_RANGE_CHECK:
        return instruction_cycle_timing_pkg::EA_FETCH_IMM;
      instruction_cycle_timing_pkg::OP_JUMP, instruction_cycle_timing_pkg::OP_JUMP_TO_SUBROUTINE:
        return instruction_cycle_timing_pkg::EA_JUMP;
      instruction_cycle_timing_pkg::OP_REGISTER_BOUNDS_CHECK:
        return instruction_cycle_timing_pkg::EA_FETCH;
      instruction_cycle_timing_pkg::OP_LOAD_EFFECTIVE_ADDRESS,
      instruction_cycle_timing_pkg::OP_PUSH_EFFECTIVE_ADDRESS:
        return instruction_cycle_timing_pkg::EA_CALC;
      default: return instruction_cycle_timing_pkg::EA_NONE;
    endcase
  endfunction

  state_e state;
  logic [instruction_cycle_timing_pkg::TOTAL_W-1:0] remaining;

  wire logic is_bit_field;
  wire instruction_cycle_timing_pkg::form_e form;
  wire instruction_cycle_timing_pkg::row_t row;
  wire logic [1:0] column;
  wire instruction_cycle_timing_pkg::ea_e ea_kind;
  wire instruction_cycle_timing_pkg::timing_s base;
  wire logic [instruction_cycle_timing_pkg::TOTAL_W-1:0] ea_add;
  wire logic is_copy;
  wire instruction_cycle_timing_pkg::result_s next_result;
  wire logic accept;
  wire logic last;

  // Row lookup; five-byte field selects the two-operand-cycle row
  assign is_bit_field = req.op <= instruction_cycle_timing_pkg::OP_BF_FIND_FIRST_ONE;
  assign form = !req.on_memory ? instruction_cycle_timing_pkg::FORM_REG :
                req.span_five ? instruction_cycle_timing_pkg::FORM_MEM_FIVE :
                instruction_cycle_timing_pkg::FORM_MEM_FOUR;
  assign row = is_bit_field ? bf_row(req.op, form) : ctl_row(req.op);

  // Column from cache hit and prefetch overlap
  assign column = (req.icache_hit && req.prefetch_overlap) ? 2'(instruction_cycle_timing_pkg::COL_IDX_BEST) :
                  req.icache_hit ? 2'(instruction_cycle_timing_pkg::COL_IDX_CACHE) :
                  2'(instruction_cycle_timing_pkg::COL_IDX_WORST);
  assign base = row[column];

  // Totals; bus cycles stay inside the total, only address time and copies add
  assign ea_kind = ea_of(req.op, req.on_memory);
  assign ea_add = (ea_kind == instruction_cycle_timing_pkg::EA_NONE) ? 16'h0000 :
                  {8'h00, req.ea_clocks};
  assign is_copy = req.op == instruction_cycle_timing_pkg::OP_MODULE_CALL_TYPE1_COPY;
  assign next_result.timing.total = base.total + ea_add + (is_copy ?
      16'(instruction_cycle_timing_pkg::COPY_CLOCKS_PER_TRANSFER * req.transfers) : 16'h0000);
  assign next_result.timing.reads = base.reads + (is_copy ?
      8'(instruction_cycle_timing_pkg::COPY_READS_PER_TRANSFER * req.transfers) : 8'h00);
  assign next_result.timing.prefetches = base.prefetches;
  assign next_result.timing.writes = base.writes + (is_copy ?
      8'(instruction_cycle_timing_pkg::COPY_WRITES_PER_TRANSFER * req.transfers) : 8'h00);
  assign next_result.ea_kind = ea_kind;
  assign next_result.column = column;

  // Handshake
  assign ready = state == ST_IDLE;
  assign accept = start && ready;
  assign last = remaining <= 16'h0001;

  // Result register, taken on acceptance
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      result <= '0;
    end else if (accept) begin
      result <= next_result;
    end
  end

  // Counts out the total, one clock per edge
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state <= ST_IDLE;
      remaining <= 16'h0000;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (state)
        ST_IDLE: begin
          if (accept) begin
            state <= ST_RUN;
            remaining <= next_result.timing.total;
          end
        end
        ST_RUN: begin
          remaining <= remaining - 16'h0001;
          if (last) begin
            state <= ST_IDLE;
            remaining <= 16'h0000;
            done <= 1'b1;
          end
        end
      endcase
    end
  end

  assign busy = state == ST_RUN;

endmodule // instruction_cycle_timing

`default_nettype wire

// ==== design/instruction_cycle_timing_pkg.sv ====
`default_nettype none
package instruction_cycle_timing_pkg;

  // Widths of the counts carried in a timing record
  localparam int TOTAL_W = 16;
  localparam int BUS_W = 8;

  // Cost of one stack-copy transfer in a type-1 module call
  localparam logic [TOTAL_W-1:0] COPY_CLOCKS_PER_TRANSFER = 16'h0006;
  localparam logic [BUS_W-1:0] COPY_READS_PER_TRANSFER = 8'h01;
  localparam logic [BUS_W-1:0] COPY_WRITES_PER_TRANSFER = 8'h01;

  // Column indices within a timing row
  localparam int COL_IDX_BEST = 0;
  localparam int COL_IDX_CACHE = 1;
  localparam int COL_IDX_WORST = 2;

  typedef enum logic [4:0] {
    OP_BF_TEST, OP_BF_CHANGE, OP_BF_CLEAR, OP_BF_SET,
    OP_BF_EXTRACT_SIGNED, OP_BF_EXTRACT_UNSIGNED, OP_BF_INSERT, OP_BF_FIND_FIRST_ONE,
    OP_BRANCH_TAKEN, OP_BRANCH_BYTE_NOT_TAKEN, OP_BRANCH_WORD_NOT_TAKEN,
    OP_BRANCH_LONG_NOT_TAKEN,
    OP_DECREMENT_AND_BRANCH_LOOP, OP_DECREMENT_AND_BRANCH_EXPIRED,
    OP_DECREMENT_AND_BRANCH_TRUE,
    OP_MODULE_CALL_TYPE0, OP_MODULE_CALL_TYPE1_NO_COPY, OP_MODULE_CALL_TYPE1_NO_COPY_ALT,
    OP_MODULE_CALL_TYPE1_COPY,
    OP_JUMP, OP_JUMP_TO_SUBROUTINE, OP_REGISTER_BOUNDS_CHECK, OP_TWO_BOUND_RANGE_CHECK,
    OP_LOAD_EFFECTIVE_ADDRESS, OP_PUSH_EFFECTIVE_ADDRESS, OP_NOP
  } op_e;

  typedef enum logic [1:0] {FORM_REG, FORM_MEM_FOUR, FORM_MEM_FIVE} form_e;

  typedef enum logic [2:0] {
    EA_NONE, EA_CALC_IMM, EA_FETCH_IMM, EA_FETCH, EA_CALC, EA_JUMP
  } ea_e;

  typedef struct packed {
    logic [TOTAL_W-1:0] total;
    logic [BUS_W-1:0] reads;
    logic [BUS_W-1:0] prefetches;
    logic [BUS_W-1:0] writes;
  } timing_s;

  // Worst, cache, best from high to low
  typedef timing_s [2:0] row_t;

  typedef struct packed {
    op_e op;
    logic icache_hit;
    logic prefetch_overlap;
    logic on_memory;
    logic span_five;
    logic [BUS_W-1:0] ea_clocks;
    logic [BUS_W-1:0] transfers;
  } request_s;

  typedef struct packed {
    timing_s timing;
    ea_e ea_kind;
    logic [1:0] column;
  } result_s;

endpackage
`default_nettype wire

// ==== bench/instruction_cycle_timing_monitor.sv ====
`timescale 1ns/1ns
`default_nettype none
module instruction_cycle_timing_monitor (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Request side
  input wire logic start,
  input wire instruction_cycle_timing_pkg::request_s req,
  input wire logic ready,
  // Answer side
  input wire instruction_cycle_timing_pkg::result_s result,
  input wire logic busy,
  input wire logic done
);
  logic [15:0] cnt;
  wire take = start && ready;
  wire [15:0] tgt = (result.timing.total == 16'h0000) ? 16'h0001 : result.timing.total;
  // Cycles since the last accepted request
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) cnt <= 16'h0000;
    else if (take) cnt <= 16'h0000;
    else cnt <= cnt + 16'h0001;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  a_done_count: assert property (done |-> cnt == tgt)
    else $error("done at wrong cycle");
  a_busy_refuse: assert property (busy |-> !ready ##1 $stable(result))
    else $error("request taken while busy");
  a_column_pick: assert property (take |=> result.column ==
    ($past(req.icache_hit) ? ($past(req.prefetch_overlap) ? 2'h0 : 2'h1) : 2'h2))
    else $error("wrong column");
  a_branch_plain: assert property (take
    && req.op >= instruction_cycle_timing_pkg::OP_BRANCH_TAKEN
    && req.op <= instruction_cycle_timing_pkg::OP_DECREMENT_AND_BRANCH_TRUE
    |=> result.ea_kind == instruction_cycle_timing_pkg::EA_NONE)
    else $error("branch given address time");
  a_jump_worst: assert property (take && req.op == instruction_cycle_timing_pkg::OP_JUMP
    && !req.icache_hit |=> result.timing.total == 16'h0007 + {8'h00, $past(req.ea_clocks)}
    && result.timing.prefetches == 8'h02)
    else $error("jump worst count");
  a_copy_cost: assert property (take && !req.icache_hit
    && req.op == instruction_cycle_timing_pkg::OP_MODULE_CALL_TYPE1_COPY
    |=> result.timing.total == 16'h0047 + 16'h0006 * {8'h00, $past(req.transfers)}
    + {8'h00, $past(req.ea_clocks)} && result.timing.reads == 8'h07 + $past(req.transfers)
    && result.timing.writes == 8'h08 + $past(req.transfers))
    else $error("stack copy cost");
  a_expired_cost: assert property (take && !req.icache_hit
    && req.op == instruction_cycle_timing_pkg::OP_DECREMENT_AND_BRANCH_EXPIRED
    |=> result.timing.total == 16'h000a && result.timing.prefetches == 8'h03)
    else $error("expired loop cost");
  a_bounds_fetch: assert property (take && req.icache_hit
    && req.op == instruction_cycle_timing_pkg::OP_REGISTER_BOUNDS_CHECK
    |=> result.timing.total == 16'h0008 + {8'h00, $past(req.ea_clocks)}
    && result.ea_kind == instruction_cycle_timing_pkg::EA_FETCH)
    else $error("bounds check cost");
  a_field_span: assert property (take && req.on_memory
    && req.op == instruction_cycle_timing_pkg::OP_BF_TEST
    |=> result.timing.reads == ($past(req.span_five) ? 8'h02 : 8'h01))
    else $error("operand cycles for span");
endmodule // instruction_cycle_timing_monitor
bind instruction_cycle_timing instruction_cycle_timing_monitor mon (.clk_sys(clk_sys),
  .rstn(rstn), .start(start), .req(req), .ready(ready), .result(result), .busy(busy),
  .done(done));
`default_nettype wire

// ==== bench/memory_bus_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module memory_bus_model (
  // Clock
  input wire logic clk_sys,
  // Finished count from the block
  input wire logic done,
  input wire instruction_cycle_timing_pkg::result_s result,
  // Bus cycles served beyond the clock budget
  output logic overrun
);
  // Serves the reported bus cycles, which must fit inside the count
  initial overrun = 1'b0;
  always @(posedge clk_sys) begin
    if (done === 1'b1 && ({8'h00, result.timing.reads} + result.timing.prefetches
        + result.timing.writes > result.timing.total)) overrun <= 1'b1;
  end
endmodule // memory_bus_model
`default_nettype wire

// ==== bench/test_instruction_cycle_timing.sv ====
`timescale 1ns/1ns
`default_nettype none
module test_instruction_cycle_timing;
  // Stimulus and observed ports
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic start = 1'b0;
  instruction_cycle_timing_pkg::request_s req = '0;
  logic ready, busy, done, overrun;
  instruction_cycle_timing_pkg::result_s result;
  int failures = 0;
  int checked = 0;
  initial forever #4 clk_sys = ~clk_sys;
  instruction_cycle_timing dut (.clk_sys(clk_sys), .rstn(rstn), .start(start), .req(req),
    .ready(ready), .result(result), .busy(busy), .done(done));
  memory_bus_model mem (.clk_sys(clk_sys), .done(done), .result(result), .overrun(overrun));
  // Counted comparison
  task check(input logic [44:0] seen, input logic [44:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One request; f holds hit, overlap, memory, five bytes
  task run(input instruction_cycle_timing_pkg::op_e op, input logic [3:0] f,
    input logic [7:0] ea, input logic [7:0] n, input logic [39:0] t, input logic [2:0] k);
    int c;
    @(negedge clk_sys);
    start = 1'b1;
    req = {op, f, ea, n};
    @(posedge clk_sys);
    #1;
    check(result, {t, k, f[3] ? {1'b0, ~f[2]} : 2'h2});
    @(negedge clk_sys);
    start = 1'b0;
    c = 0;
    while (done !== 1'b1 && c < 300) begin
      @(posedge clk_sys);
      #1;
      c++;
    end
    check(45'(c), {29'h0, t[39:24]});
  endtask
  task t_bit_field;
    run(instruction_cycle_timing_pkg::OP_BF_TEST, 4'hc, 8'h05, 8'h00, 40'h0003000000, 3'h0);
    run(instruction_cycle_timing_pkg::OP_BF_TEST, 4'h2, 8'h04, 8'h00, 40'h0010010100, 3'h1);
    run(instruction_cycle_timing_pkg::OP_BF_TEST, 4'hb, 8'h04, 8'h00, 40'h0013020000, 3'h1);
    run(instruction_cycle_timing_pkg::OP_BF_INSERT, 4'h3, 8'h01, 8'h00, 40'h0016020102, 3'h1);
    run(instruction_cycle_timing_pkg::OP_BF_SET, 4'h6, 8'h02, 8'h00,
      40'h0012010101, 3'h1);
    run(instruction_cycle_timing_pkg::OP_BF_EXTRACT_UNSIGNED, 4'hd, 8'h02, 8'h00,
      40'h0005000000, 3'h0);
    $display("bit field test done");
  endtask
  task t_branch;
    run(instruction_cycle_timing_pkg::OP_BRANCH_TAKEN, 4'hc, 8'h07, 8'h00, 40'h0003000000, 3'h0);
    run(instruction_cycle_timing_pkg::OP_BRANCH_TAKEN, 4'h8, 8'h07, 8'h00, 40'h0006000000, 3'h0);
    run(instruction_cycle_timing_pkg::OP_BRANCH_TAKEN, 4'h0, 8'h07, 8'h00, 40'h0009000200, 3'h0);
    run(instruction_cycle_timing_pkg::OP_DECREMENT_AND_BRANCH_LOOP, 4'h0, 8'h02, 8'h00,
      40'h0009000200, 3'h0);
    run(instruction_cycle_timing_pkg::OP_DECREMENT_AND_BRANCH_LOOP, 4'hc, 8'h02, 8'h00,
      40'h0003000000, 3'h0);
    run(instruction_cycle_timing_pkg::OP_DECREMENT_AND_BRANCH_EXPIRED, 4'h8, 8'h02, 8'h00,
      40'h000a000000, 3'h0);
    run(instruction_cycle_timing_pkg::OP_DECREMENT_AND_BRANCH_EXPIRED, 4'h0, 8'h02, 8'h00,
      40'h000a000300, 3'h0);
    run(instruction_cycle_timing_pkg::OP_BRANCH_BYTE_NOT_TAKEN, 4'hc, 8'h01, 8'h00,
      40'h0001000000, 3'h0);
    run(instruction_cycle_timing_pkg::OP_BRANCH_LONG_NOT_TAKEN, 4'h0, 8'h01, 8'h00,
      40'h0009000200, 3'h0);
    run(instruction_cycle_timing_pkg::OP_DECREMENT_AND_BRANCH_TRUE, 4'h0, 8'h03, 8'h00,
      40'h0007000100, 3'h0);
    $display("branch test done");
  endtask
  task t_control;
    run(instruction_cycle_timing_pkg::OP_MODULE_CALL_TYPE1_COPY, 4'h0, 8'h03, 8'h02,
      40'h005609020a, 3'h2);
    run(instruction_cycle_timing_pkg::OP_MODULE_CALL_TYPE1_COPY, 4'hc, 8'h00, 8'h00,
      40'h003f070008, 3'h2);
    run(instruction_cycle_timing_pkg::OP_MODULE_CALL_TYPE0, 4'h8, 8'h02, 8'h00,
      40'h0020020006, 3'h2);
    run(instruction_cycle_timing_pkg::OP_TWO_BOUND_RANGE_CHECK, 4'hc, 8'h01, 8'h00,
      40'h0011020000, 3'h2);
    run(instruction_cycle_timing_pkg::OP_JUMP, 4'hc, 8'h00, 8'h00, 40'h0001000000, 3'h5);
    run(instruction_cycle_timing_pkg::OP_JUMP, 4'h0, 8'h02, 8'h00, 40'h0009000200, 3'h5);
    run(instruction_cycle_timing_pkg::OP_REGISTER_BOUNDS_CHECK, 4'h8, 8'h04, 8'h00,
      40'h000c000000, 3'h3);
    run(instruction_cycle_timing_pkg::OP_LOAD_EFFECTIVE_ADDRESS, 4'hc, 8'h03, 8'h00,
      40'h0005000000, 3'h4);
    run(instruction_cycle_timing_pkg::OP_PUSH_EFFECTIVE_ADDRESS, 4'h0, 8'h02, 8'h00,
      40'h0008000101, 3'h4);
    run(instruction_cycle_timing_pkg::OP_JUMP_TO_SUBROUTINE, 4'h8, 8'h01, 8'h00,
      40'h0006000001, 3'h5);
    run(instruction_cycle_timing_pkg::OP_MODULE_CALL_TYPE1_NO_COPY, 4'hc, 8'h01, 8'h03,
      40'h0031050008, 3'h2);
    run(instruction_cycle_timing_pkg::OP_MODULE_CALL_TYPE1_NO_COPY_ALT, 4'h8, 8'h00, 8'h00,
      40'h0039060008, 3'h2);
    $display("control test done");
  endtask
  // Second request while counting is ignored
  task t_refused;
    @(negedge clk_sys);
    start = 1'b1;
    req = {instruction_cycle_timing_pkg::OP_BF_FIND_FIRST_ONE, 4'h3, 8'h00, 8'h00};
    @(posedge clk_sys);
    @(negedge clk_sys);
    req = {instruction_cycle_timing_pkg::OP_JUMP, 4'hc, 8'h00, 8'h00};
    repeat (6) @(posedge clk_sys);
    #1;
    check(result, {40'h0020020100, 3'h1, 2'h2});
    check({44'h0, ready}, 45'h0);
    check({44'h0, busy}, 45'h1);
    @(negedge clk_sys);
    start = 1'b0;
    repeat (40) @(posedge clk_sys);
    #1;
    check(result, {40'h0020020100, 3'h1, 2'h2});
    check({44'h0, busy}, 45'h0);
    $display("refused test done");
  endtask
  // Verdict and end of run
  task wrap_up;
    check({44'h0, overrun}, 45'h0);
    $display("Checked %0d, failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (12) @(posedge clk_sys);
    @(negedge clk_sys);
    rstn = 1'b1;
    t_bit_field();
    t_branch();
    t_control();
    t_refused();
    wrap_up();
  end
  // Watchdog, well past the expected run
  initial begin
    #80000;
    failures++;
    wrap_up();
  end
endmodule // test_instruction_cycle_timing
`default_nettype wire
